/* File: include/drp_defines.svh */
`ifndef DRP_DEFINES_SVH
`define DRP_DEFINES_SVH
// ----------------------------------------------------------------------
// Cell offsets
// ----------------------------------------------------------------------
`define DRP_ADDR_STATUS      7'h00
`define DRP_ADDR_SYNTH_RANGE 7'h41
`define DRP_ADDR_MULDIV      7'h50
`define DRP_ADDR_DLL_RANGE   7'h51
// ----------------------------------------------------------------------
// Field positions and maximum values
// ----------------------------------------------------------------------
`define DRP_SYNTH_RANGE_BIT  2
`define DRP_DLL_RANGE_LO     2
`define DRP_DLL_RANGE_HI     3
`define DRP_MUL_LO           8
`define DRP_MUL_HI           15
`define DRP_DIV_LO           0
`define DRP_DIV_HI           7
`define DRP_MUL_MAX          8'h20
`define DRP_DIV_MAX          8'h1f
// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define DRP_WAIT_CYCLES      2'h2
`endif

/* File: include/drp_pkg.sv */
package drp_pkg;
  // Port sequencer states, one-hot
  typedef enum logic [2:0] {
    DRP_IDLE = 3'b001,
    DRP_WAIT = 3'b010,
    DRP_DONE = 3'b100
  } drp_state_t;
endpackage : drp_pkg

/* File: hdl/drp_cell_mem.sv */
`include "drp_defines.svh"
// Configuration cell array; read data registered
module drp_cell_mem
  import drp_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  output logic      [DW-1:0] cell_muldiv,
  output logic      [DW-1:0] cell_synth,
  output logic      [DW-1:0] cell_dll
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // ----------------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end

  // Cell outputs drive the functional block
  assign cell_muldiv = mem_r[`DRP_ADDR_MULDIV];
  assign cell_synth  = mem_r[`DRP_ADDR_SYNTH_RANGE];
  assign cell_dll    = mem_r[`DRP_ADDR_DLL_RANGE];
endmodule : drp_cell_mem

/* File: hdl/drp_port.sv */
`include "drp_defines.svh"
module drp_port
  import drp_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          port_enable,
  input  wire logic          write_strobe,
  input  wire logic [AW-1:0] cell_address,
  input  wire logic [DW-1:0] write_data_bus,
  input  wire logic [DW-1:0] status_in,
  output logic      [DW-1:0] read_data_bus,
  output logic               cycle_done,
  output logic      [7:0]    mul_factor,
  output logic      [7:0]    div_factor,
  output logic               mul_valid,
  output logic               synth_high_range,
  output logic      [1:0]    dll_range
);
  drp_state_t    state_r;
  logic          en_r;
  logic          we_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic          op_wr_r;
  logic [1:0]    wait_r;
  logic [DW-1:0] mem_rdata;
  logic [DW-1:0] cell_muldiv;
  logic [DW-1:0] cell_synth;
  logic [DW-1:0] cell_dll;
  logic          mem_we;
  logic          take_r;
  logic [1:0]    inflight_r;

  // Status cell address reads status, writes still land in array cell 00h
  function automatic logic is_status(input logic [AW-1:0] a);
    is_status = (a == `DRP_ADDR_STATUS);
  endfunction : is_status

  // Busy while a taken enable is pending or the wait states run
  function automatic logic is_busy(input drp_state_t s, input logic pend);
    is_busy = (s == DRP_WAIT) || pend;
  endfunction : is_busy

  // ----------------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      we_r <= 1'b0;
    end else begin
      en_r <= port_enable;
      we_r <= port_enable & write_strobe;
    end
  end

  // Enable taken only when not busy (idle or done); an enable while busy is dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      take_r <= 1'b0;
    end else begin
      take_r <= port_enable && !is_busy(state_r, take_r);
    end
  end

  // Address and data captured only with an enable that is taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (port_enable && !is_busy(state_r, take_r)) begin
      addr_r  <= cell_address;
      wdata_r <= write_data_bus;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= DRP_IDLE;
      op_wr_r <= 1'b0;
      wait_r  <= '0;
    end else begin
      case (state_r)
        DRP_IDLE, DRP_DONE: begin
          if (take_r) begin
            state_r <= DRP_WAIT;
            op_wr_r <= we_r;
            wait_r  <= `DRP_WAIT_CYCLES;
          end else begin
            state_r <= DRP_IDLE;
          end
        end
        DRP_WAIT: begin
          if (wait_r == 2'h1) begin
            state_r <= DRP_DONE;
          end
          wait_r <= wait_r - 2'h1;
        end
        default: state_r <= DRP_IDLE;
      endcase
    end
  end

  // Write lands one cycle into the wait, before done
  assign mem_we = (state_r == DRP_WAIT) && op_wr_r &&
                  (wait_r == `DRP_WAIT_CYCLES);

  drp_cell_mem #(
    .AW (AW),
    .DW (DW)
  ) u_mem (
    .clk_sys     (clk_sys),
    .we          (mem_we),
    .waddr       (addr_r),
    .wdata       (wdata_r),
    .raddr       (addr_r),
    .rdata       (mem_rdata),
    .cell_muldiv (cell_muldiv),
    .cell_synth  (cell_synth),
    .cell_dll    (cell_dll)
  );

  // ----------------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------------
  assign cycle_done = (state_r == DRP_DONE);

  // Read data straight from the array or status, not re-registered
  always_comb begin
    read_data_bus = mem_rdata;
    if (is_status(addr_r)) begin
      read_data_bus = status_in;
    end
  end

  // Cell fields steer the functional block
  always_comb begin
    mul_factor       = cell_muldiv[`DRP_MUL_HI:`DRP_MUL_LO] + 8'h01;
    div_factor       = cell_muldiv[`DRP_DIV_HI:`DRP_DIV_LO] + 8'h01;
    mul_valid        = (cell_muldiv[`DRP_MUL_HI:`DRP_MUL_LO] != 8'h00) &&
                       (cell_muldiv[`DRP_MUL_HI:`DRP_MUL_LO] <=
                        `DRP_MUL_MAX);
    synth_high_range = cell_synth[`DRP_SYNTH_RANGE_BIT];
    dll_range        = cell_dll[`DRP_DLL_RANGE_HI:`DRP_DLL_RANGE_LO];
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_accept;
    take_r && (state_r != DRP_WAIT);
  endsequence

  // Two wait cycles with done low
  sequence s_wait_states;
    !cycle_done ##1 !cycle_done;
  endsequence

  // Operations in flight: up on a taken enable, down on done
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inflight_r <= 2'h0;
    end else begin
      inflight_r <= inflight_r + {1'b0, take_r} - {1'b0, cycle_done};
    end
  end

  property p_done_one;
    @(posedge clk_sys) disable iff (!rst_n)
      cycle_done |=> !cycle_done || $past(en_r);
  endproperty
  a_done_one: assert property (p_done_one) else $error("done too long");

  property p_done_lat;
    @(posedge clk_sys) disable iff (!rst_n)
      s_accept |=> s_wait_states ##1 cycle_done;
  endproperty
  a_done_lat: assert property (p_done_lat) else $error("done latency");

  property p_no_spur;
    @(posedge clk_sys) disable iff (!rst_n)
      cycle_done |-> $past(take_r, 3);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious done");

  property p_idle_ign;
    @(posedge clk_sys) disable iff (!rst_n)
      !port_enable |=> !en_r && !we_r;
  endproperty
  a_idle_ign: assert property (p_idle_ign) else $error("idle taken");

  property p_wr_kind;
    @(posedge clk_sys) disable iff (!rst_n)
      s_accept |=> op_wr_r == $past(we_r);
  endproperty
  a_wr_kind: assert property (p_wr_kind) else $error("wrong kind");

  property p_wr_before;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_done && op_wr_r) |-> $past(mem_we, 2);
  endproperty
  a_wr_before: assert property (p_wr_before) else $error("late write");

  property p_rd_data;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_done && !op_wr_r && !is_status(addr_r)) |->
        read_data_bus == mem_rdata;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data");

  property p_mul;
    @(posedge clk_sys) disable iff (!rst_n)
      mul_factor == cell_muldiv[15:8] + 8'h01;
  endproperty
  a_mul: assert property (p_mul) else $error("multiplier");

  property p_done_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      cycle_done |=> !cycle_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done twice");

  property p_busy_refuse;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == DRP_WAIT) |-> !take_r;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("enable taken while busy");

  property p_rd_status;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_done && !op_wr_r && is_status(addr_r)) |->
        read_data_bus == status_in;
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read data");

  property p_rd_cell;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_done && !op_wr_r && addr_r == `DRP_ADDR_MULDIV) |->
        read_data_bus == cell_muldiv;
  endproperty
  a_rd_cell: assert property (p_rd_cell)
    else $error("cell read data");

  property p_wr_lands;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_done && op_wr_r && addr_r == `DRP_ADDR_MULDIV) |->
        cell_muldiv == wdata_r;
  endproperty
  a_wr_lands: assert property (p_wr_lands)
    else $error("write not landed");

  property p_stray_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !port_enable |=> $stable(addr_r) && $stable(wdata_r);
  endproperty
  a_stray_hold: assert property (p_stray_hold)
    else $error("stray capture");

  property p_mul_valid;
    @(posedge clk_sys) disable iff (!rst_n)
      (cell_muldiv[`DRP_MUL_HI:`DRP_MUL_LO] == 8'h00) |-> !mul_valid;
  endproperty
  a_mul_valid: assert property (p_mul_valid)
    else $error("zero multiplier valid");

  property p_one_op;
    @(posedge clk_sys) disable iff (!rst_n)
      cycle_done |-> inflight_r == 2'h1;
  endproperty
  a_one_op: assert property (p_one_op)
    else $error("done without operation");

  property p_no_pile;
    @(posedge clk_sys) disable iff (!rst_n)
      inflight_r <= 2'h1;
  endproperty
  a_no_pile: assert property (p_no_pile)
    else $error("operations piled up");
endmodule : drp_port

/* File: tb/drp_master_model.sv */
// Fabric-side port master: one operation at a time, pulses enable once
module drp_master_model (
  input  wire logic        clk_sys,
  input  wire logic        cycle_done,
  input  wire logic [15:0] read_data_bus,
  output logic             port_enable,
  output logic             write_strobe,
  output logic [6:0]       cell_address,
  output logic [15:0]      write_data_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    port_enable    = 1'b0;
    write_strobe   = 1'b0;
    cell_address   = 7'h00;
    write_data_bus = 16'h0000;
  end
  // Call at a falling edge; returns in the done cycle so the next op overlaps
  task automatic op(input logic wr, input logic [6:0] a,
                    input logic [15:0] d, output logic [15:0] q,
                    output logic ok);
    int n;
    port_enable    = 1'b1;
    write_strobe   = wr;
    cell_address   = a;
    write_data_bus = d;
    @(negedge clk_sys);
    port_enable    = 1'b0;
    write_strobe   = 1'b0;
    cell_address   = ~a;
    write_data_bus = ~d;
    ok             = 1'b0;
    q              = 16'h0000;
    for (n = 0; n < 16 && !ok; n++) begin
      if (cycle_done === 1'b1) begin
        q  = read_data_bus;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask : op
  // Strobe, address and data wiggle with enable low
  task automatic stray(input logic [6:0] a, input logic [15:0] d);
    write_strobe   = 1'b1;
    cell_address   = a;
    write_data_bus = d;
    repeat (6) @(negedge clk_sys);
    write_strobe   = 1'b0;
  endtask : stray
endmodule : drp_master_model

/* File: tb/test_dynamic_reconfig_port.sv */
module test_dynamic_reconfig_port;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys, rst_n, port_enable, write_strobe, cycle_done;
  logic        mul_valid, synth_high_range, done_prev, synth_hold;
  logic [6:0]  cell_address;
  logic [15:0] write_data_bus, read_data_bus, status_in, ratio_prev;
  logic [7:0]  mul_factor, div_factor;
  logic [1:0]  dll_range;
  int          mismatches, cmp_count, n_en, n_done;
  drp_port #(.AW(7), .DW(16)) i_drp_port (
    .clk_sys(clk_sys), .rst_n(rst_n), .port_enable(port_enable),
    .write_strobe(write_strobe), .cell_address(cell_address),
    .write_data_bus(write_data_bus), .status_in(status_in),
    .read_data_bus(read_data_bus), .cycle_done(cycle_done),
    .mul_factor(mul_factor), .div_factor(div_factor),
    .mul_valid(mul_valid), .synth_high_range(synth_high_range),
    .dll_range(dll_range));
  drp_master_model i_drp_master_model (
    .clk_sys(clk_sys), .cycle_done(cycle_done),
    .read_data_bus(read_data_bus), .port_enable(port_enable),
    .write_strobe(write_strobe), .cell_address(cell_address),
    .write_data_bus(write_data_bus));
  // Clock at 4 ns
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;
  // Done pulses counted; two high cycles in a row is a fault
  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && cycle_done === 1'b1) begin
      n_done++;
      chk("done_single", 16'h0000, {15'h0000, done_prev});
    end
    // Ratio outputs may only move while the synthesizer is held
    if (rst_n === 1'b1 && {mul_factor, div_factor} !== ratio_prev) begin
      chk("ratio_in_reset", 16'h0001, {15'h0000, synth_hold});
    end
    done_prev  <= (cycle_done === 1'b1);
    ratio_prev <= {mul_factor, div_factor};
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op_chk(input logic wr, input logic [6:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    logic ok;
    n_en++;
    i_drp_master_model.op(wr, a, d, q, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error op_done expected 1 seen 0");
      end_of_test();
    end
  endtask : op_chk
  // Each access to a cell other than 00h is followed by a status read of 00h
  task automatic acc(input logic wr, input logic [6:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    logic [15:0] s;
    op_chk(wr, a, d, q);
    if (a != 7'h00) begin
      op_chk(1'b0, 7'h00, 16'h0000, s);
      chk("status_after", status_in, s);
    end
  endtask : acc
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status;
    logic [15:0] q;
    status_in = 16'hc3a6;
    acc(1'b1, 7'h00, 16'h1234, q);
    acc(1'b0, 7'h00, 16'h0000, q);
    chk("status_rd", 16'hc3a6, q);
    $display("t_status finished");
  endtask : t_status
  task automatic t_muldiv;
    logic [15:0] q;
    logic [7:0]  m [3] = '{8'h20, 8'h00, 8'h10};
    logic [7:0]  d [3] = '{8'h1f, 8'h00, 8'h0a};
    synth_hold = 1'b1;
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 7'h50, {m[i], d[i]}, q);
      acc(1'b0, 7'h50, 16'h0000, q);
      chk("muldiv_rd", {m[i], d[i]}, q);
      chk("mul_factor", {8'h00, m[i] + 8'h01}, {8'h00, mul_factor});
      chk("div_factor", {8'h00, d[i] + 8'h01}, {8'h00, div_factor});
      chk("mul_valid", {15'h0000, m[i] != 8'h00 && m[i] <= 8'h20},
          {15'h0000, mul_valid});
    end
    acc(1'b0, 7'h50, 16'h0000, q);
    acc(1'b1, 7'h50, {q[15:8], 8'h03}, q);
    synth_hold = 1'b0;
    chk("rmw_mul", 16'h0011, {8'h00, mul_factor});
    chk("rmw_div", 16'h0004, {8'h00, div_factor});
    $display("t_muldiv finished");
  endtask : t_muldiv
  task automatic t_ranges;
    logic [15:0] q;
    acc(1'b1, 7'h41, 16'ha5a1, q);
    chk("synth_low", 16'h0000, {15'h0000, synth_high_range});
    acc(1'b0, 7'h41, 16'h0000, q);
    acc(1'b1, 7'h41, q | 16'h0004, q);
    acc(1'b0, 7'h41, 16'h0000, q);
    chk("synth_rd", 16'ha5a5, q);
    chk("synth_high", 16'h0001, {15'h0000, synth_high_range});
    acc(1'b1, 7'h51, 16'h5a53, q);
    chk("dll_low", 16'h0000, {14'h0000, dll_range});
    acc(1'b0, 7'h51, 16'h0000, q);
    acc(1'b1, 7'h51, q | 16'h000c, q);
    acc(1'b0, 7'h51, 16'h0000, q);
    chk("dll_rd", 16'h5a5f, q);
    chk("dll_high", 16'h0003, {14'h0000, dll_range});
    $display("t_ranges finished");
  endtask : t_ranges
  task automatic t_stray;
    i_drp_master_model.stray(7'h50, 16'hffff);
    chk("stray_mul", 16'h0011, {8'h00, mul_factor});
    chk("done_count", n_en[15:0], n_done[15:0]);
    $display("t_stray finished");
  endtask : t_stray
  // Reset for 12 cycles, then the scenarios back to back
  initial begin
    rst_n     = 1'b0;
    status_in = 16'h0000;
    synth_hold = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    t_status;
    t_muldiv;
    t_ranges;
    t_stray;
    end_of_test();
  end
endmodule : test_dynamic_reconfig_port
